// ### hdl/nctd_map.vh
// Constants for the nibble core transfer decoder
// Contract
// RULE_01: copy_x_to_acc (0x052) loads accumulator with X.
// RULE_02: copy_stack_ptr_to_acc (0x050) loads acc[2:0] from stack pointer, clears acc[3].
// RULE_03: load_x_y_immediate (top bits 11) writes bits 7-4 to X, 3-0 to Y.
// RULE_04: In a run of load_x_y_immediate words only the first takes effect.
// RULE_05: load_z_immediate (0x048+z) writes code bits 1-0 into Z.
// RULE_06: increment_y (0x013) adds one to Y modulo 16.
// RULE_07: After any Y increment, skip next instruction when new Y is 0.
// RULE_08: decrement_y (0x017) subtracts one from Y modulo 16.
// RULE_09: After any Y decrement, skip next instruction when new Y is 15.
// RULE_10: load_acc_from_ram (0x2C0|j) loads acc from RAM, then X becomes X xor j.
// RULE_11: swap_acc_ram (0x2D0|j) exchanges acc and RAM nibble, X becomes X xor j.
// RULE_12: swap_acc_ram_dec (0x2F0|j) swaps, xors X with j, and decrements Y.
// RULE_13: swap_acc_ram_inc (0x2E0|j) swaps, xors X with j, and increments Y.
// RULE_14: store_acc_to_ram (0x2B0|j) writes acc to RAM, X becomes X xor j.
// RULE_15: copy_b_to_acc loads accumulator with B.
// RULE_16: copy_acc_to_b loads B with accumulator.
// RULE_17: copy_y_to_acc loads accumulator with Y.
// RULE_18: copy_acc_to_y loads Y with accumulator.
// RULE_19: pack_into_e puts B into E[7:4] and accumulator into E[3:0].
// RULE_20: unpack_from_e loads B from E[7:4] and accumulator from E[3:0].
// RULE_21: copy_acc_to_d loads 3-bit D from acc[2:0], ignoring acc[3].
// RULE_22: Each instruction is one word, one instruction cycle, carry flag untouched.
// RULE_23: RAM write only for swap and store; load only reads at the pointer.
`ifndef NCTD_MAP_VH
`define NCTD_MAP_VH

// Fixed instruction codes
`define NCTD_C_COPY_X_TO_ACC  10'h052
`define NCTD_C_COPY_SP_TO_ACC 10'h050
`define NCTD_C_INC_Y          10'h013
`define NCTD_C_DEC_Y          10'h017
`define NCTD_C_COPY_B_TO_ACC  10'h01E
`define NCTD_C_COPY_ACC_TO_B  10'h00E
`define NCTD_C_COPY_Y_TO_ACC  10'h01F
`define NCTD_C_COPY_ACC_TO_Y  10'h00C
`define NCTD_C_PACK_E         10'h01A
`define NCTD_C_UNPACK_E       10'h02A
`define NCTD_C_COPY_ACC_TO_D  10'h029

// Prefix codes of immediate instructions
`define NCTD_P_LXY            2'h3
`define NCTD_P_LZ             8'h12
`define NCTD_P_LOAD_RAM       6'h2C
`define NCTD_P_SWAP_RAM       6'h2D
`define NCTD_P_SWAP_RAM_INC   6'h2E
`define NCTD_P_SWAP_RAM_DEC   6'h2F
`define NCTD_P_STORE_RAM      6'h2B

// One-hot operation vector bit positions
`define NCTD_OP_W             18
`define NCTD_OP_X_TO_ACC      0
`define NCTD_OP_SP_TO_ACC     1
`define NCTD_OP_LXY           2
`define NCTD_OP_LZ            3
`define NCTD_OP_INC_Y         4
`define NCTD_OP_DEC_Y         5
`define NCTD_OP_LOAD_RAM      6
`define NCTD_OP_SWAP_RAM      7
`define NCTD_OP_SWAP_DEC      8
`define NCTD_OP_SWAP_INC      9
`define NCTD_OP_STORE_RAM     10
`define NCTD_OP_B_TO_ACC      11
`define NCTD_OP_ACC_TO_B      12
`define NCTD_OP_Y_TO_ACC      13
`define NCTD_OP_ACC_TO_Y      14
`define NCTD_OP_PACK_E        15
`define NCTD_OP_UNPACK_E      16
`define NCTD_OP_ACC_TO_D      17

// Skip values after a Y step
`define NCTD_Y_INC_SKIP       4'h0
`define NCTD_Y_DEC_SKIP       4'hF

// Reset values
`define NCTD_RST_NIB          4'h0
`define NCTD_RST_D            3'h0
`define NCTD_RST_E            8'h00
`define NCTD_RST_Z            2'h0

`endif

// ### hdl/nctd_decode.v
// Instruction word to one-hot operation decoder
`timescale 1ns/1ps
`default_nettype none
`include "nctd_map.vh"
module nctd_decode (
  // Instruction word
  input  wire [9:0]             instr_i,
  // Decoded operation, all zero for codes outside the group
  output reg  [`NCTD_OP_W-1:0]  op_o
);

  always @* begin
    op_o = {`NCTD_OP_W{1'b0}};
    op_o[`NCTD_OP_X_TO_ACC]  = (instr_i == `NCTD_C_COPY_X_TO_ACC);
    op_o[`NCTD_OP_SP_TO_ACC] = (instr_i == `NCTD_C_COPY_SP_TO_ACC);
    op_o[`NCTD_OP_LXY]       = (instr_i[9:8] == `NCTD_P_LXY);
    op_o[`NCTD_OP_LZ]        = (instr_i[9:2] == `NCTD_P_LZ);
    op_o[`NCTD_OP_INC_Y]     = (instr_i == `NCTD_C_INC_Y);
    op_o[`NCTD_OP_DEC_Y]     = (instr_i == `NCTD_C_DEC_Y);
    op_o[`NCTD_OP_LOAD_RAM]  = (instr_i[9:4] == `NCTD_P_LOAD_RAM);
    op_o[`NCTD_OP_SWAP_RAM]  = (instr_i[9:4] == `NCTD_P_SWAP_RAM);
    op_o[`NCTD_OP_SWAP_DEC]  = (instr_i[9:4] == `NCTD_P_SWAP_RAM_DEC);
    op_o[`NCTD_OP_SWAP_INC]  = (instr_i[9:4] == `NCTD_P_SWAP_RAM_INC);
    op_o[`NCTD_OP_STORE_RAM] = (instr_i[9:4] == `NCTD_P_STORE_RAM);
    op_o[`NCTD_OP_B_TO_ACC]  = (instr_i == `NCTD_C_COPY_B_TO_ACC);
    op_o[`NCTD_OP_ACC_TO_B]  = (instr_i == `NCTD_C_COPY_ACC_TO_B);
    op_o[`NCTD_OP_Y_TO_ACC]  = (instr_i == `NCTD_C_COPY_Y_TO_ACC);
    op_o[`NCTD_OP_ACC_TO_Y]  = (instr_i == `NCTD_C_COPY_ACC_TO_Y);
    op_o[`NCTD_OP_PACK_E]    = (instr_i == `NCTD_C_PACK_E);
    op_o[`NCTD_OP_UNPACK_E]  = (instr_i == `NCTD_C_UNPACK_E);
    op_o[`NCTD_OP_ACC_TO_D]  = (instr_i == `NCTD_C_COPY_ACC_TO_D);
  end

endmodule // nctd_decode
`default_nettype wire

// ### hdl/nctd_ystep.v
// Y increment and decrement with the resulting skip condition
`timescale 1ns/1ps
`default_nettype none
`include "nctd_map.vh"
module nctd_ystep (
  // Current Y and step requests
  input  wire [3:0] y_i,
  input  wire       inc_i,
  input  wire       dec_i,
  // Stepped Y and skip request
  output reg  [3:0] y_o,
  output reg        skip_o
);

  always @* begin
    y_o    = y_i;
    skip_o = 1'b0;
    if (inc_i) begin
      y_o    = y_i + 4'h1;                       // RULE_06
      skip_o = (y_o == `NCTD_Y_INC_SKIP);        // RULE_07
    end else if (dec_i) begin
      y_o    = y_i - 4'h1;                       // RULE_08
      skip_o = (y_o == `NCTD_Y_DEC_SKIP);        // RULE_09
    end
  end

endmodule // nctd_ystep
`default_nettype wire

// ### hdl/nctd_core.v
// Transfer instruction execute unit with register file and RAM port
`timescale 1ns/1ps
`default_nettype none
`include "nctd_map.vh"
module nctd_core #(
  parameter PTR_W = 6
) (
  // Clock and reset
  input  wire             mclk_i,
  input  wire             rst_i,
  // Instruction issue from the sequencer
  input  wire             instr_valid_i,
  input  wire [9:0]       instr_i,
  input  wire [2:0]       stack_pointer_i,
  input  wire [PTR_W-1:0] ram_data_pointer_i,
  output wire             ready_o,
  output wire             done_o,
  output wire             skipped_o,
  output wire             ignored_o,
  output wire             skip_next_o,
  // Architectural registers
  output wire [3:0]       acc_o,
  output wire [3:0]       b_o,
  output wire [2:0]       d_o,
  output wire [7:0]       e_o,
  output wire [3:0]       x_o,
  output wire [3:0]       y_o,
  output wire [1:0]       z_o,
  // Data RAM port, one cycle read latency
  output wire [PTR_W-1:0] ram_addr_o,
  output wire             ram_re_o,
  output wire             ram_we_o,
  output wire [3:0]       ram_wdata_o,
  input  wire [3:0]       ram_rdata_i
);

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_EXEC = 3'h4;

  reg  [2:0]            state;
  reg  [2:0]            next_state;
  reg  [9:0]            instr_q;
  reg  [`NCTD_OP_W-1:0] op_q;
  reg                   suppress_q;
  reg                   skip_pend;
  reg                   lxy_prev;
  reg                   ready;
  reg                   done;
  reg                   skipped;
  reg                   ignored;
  reg  [3:0]            acc;
  reg  [3:0]            b;
  reg  [2:0]            d;
  reg  [7:0]            e;
  reg  [3:0]            x;
  reg  [3:0]            y;
  reg  [1:0]            z;
  reg  [PTR_W-1:0]      ram_addr;
  reg                   ram_re;
  reg                   ram_we;
  reg  [3:0]            ram_wdata;

  wire [`NCTD_OP_W-1:0] op_dec;
  wire                  take;
  wire                  suppress;
  wire                  dec_rd;
  wire                  q_swap;
  wire                  q_xor;
  wire                  q_inc;
  wire                  q_dec;
  wire [3:0]            y_step;
  wire                  y_skip;
  wire [3:0]            imm_j;

  nctd_decode u_decode (
    .instr_i (instr_i),
    .op_o    (op_dec)
  );

  nctd_ystep u_ystep (
    .y_i    (y),
    .inc_i  (q_inc),
    .dec_i  (q_dec),
    .y_o    (y_step),
    .skip_o (y_skip)
  );

  // Exchange variants of the RAM group
  function f_swap;
    input [`NCTD_OP_W-1:0] op;
    begin
      f_swap = op[`NCTD_OP_SWAP_RAM] |
               op[`NCTD_OP_SWAP_DEC] |
               op[`NCTD_OP_SWAP_INC];
    end
  endfunction

  // Operations that fetch the RAM nibble before executing
  function f_ram_read;
    input [`NCTD_OP_W-1:0] op;
    begin
      f_ram_read = f_swap(op) |
                   op[`NCTD_OP_LOAD_RAM];
    end
  endfunction

  // Operations that fold the immediate into X
  function f_x_xor;
    input [`NCTD_OP_W-1:0] op;
    begin
      f_x_xor = f_swap(op) |
                op[`NCTD_OP_LOAD_RAM] |
                op[`NCTD_OP_STORE_RAM];
    end
  endfunction

  // Operations that step Y upwards
  function f_y_inc;
    input [`NCTD_OP_W-1:0] op;
    begin
      f_y_inc = op[`NCTD_OP_INC_Y] |
                op[`NCTD_OP_SWAP_INC];
    end
  endfunction

  // Operations that step Y downwards
  function f_y_dec;
    input [`NCTD_OP_W-1:0] op;
    begin
      f_y_dec = op[`NCTD_OP_DEC_Y] |
                op[`NCTD_OP_SWAP_DEC];
    end
  endfunction

  assign take     = (state == ST_IDLE) & ready & instr_valid_i;
  // A directly repeated immediate X/Y load is dropped
  assign suppress = skip_pend | (op_dec[`NCTD_OP_LXY] & lxy_prev); // RULE_04
  // Only the load and the swaps fetch the RAM nibble
  assign dec_rd   = f_ram_read(op_dec); // RULE_23
  assign q_swap   = f_swap(op_q);
  assign q_xor    = f_x_xor(op_q);
  assign q_inc    = f_y_inc(op_q);
  assign q_dec    = f_y_dec(op_q);
  assign imm_j    = instr_q[3:0];

  // Next state of the issue sequence
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_state = ST_EXEC;
      end
      ST_EXEC: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Sequencing: take, wait for RAM data, execute
  always @(posedge mclk_i) begin
    if (rst_i) begin
      state      <= ST_IDLE;
      instr_q    <= 10'h000;
      op_q       <= {`NCTD_OP_W{1'b0}};
      suppress_q <= 1'b0;
      ready      <= 1'b0;
      done       <= 1'b0;
      skipped    <= 1'b0;
      ignored    <= 1'b0;
      ram_re     <= 1'b0;
      ram_addr   <= {PTR_W{1'b0}};
    end else begin
      done    <= 1'b0;
      skipped <= 1'b0;
      ignored <= 1'b0;
      ram_re  <= 1'b0;
      state   <= next_state;
      case (state)
        ST_IDLE: begin
          ready <= 1'b1;
          if (take) begin
            ready      <= 1'b0;
            instr_q    <= instr_i;
            op_q       <= op_dec;
            suppress_q <= suppress;
            ram_addr   <= ram_data_pointer_i;
            ram_re     <= dec_rd & ~suppress; // RULE_23
          end
        end
        ST_WAIT: begin
          ready <= 1'b0;
        end
        ST_EXEC: begin
          // Every instruction of the group ends here in one pass
          done    <= 1'b1; // RULE_22
          skipped <= suppress_q;
          ignored <= ~suppress_q & ~(|op_q);
          ready   <= 1'b1;
        end
        default: begin
          ready <= 1'b0;
        end
      endcase
    end
  end

  // Skip bookkeeping for the following instruction
  always @(posedge mclk_i) begin
    if (rst_i) begin
      skip_pend <= 1'b0;
      lxy_prev  <= 1'b0;
    end else if (take) begin
      skip_pend <= 1'b0;
      // Any word in a run counts, so a run stays dropped to its end
      lxy_prev  <= op_dec[`NCTD_OP_LXY]; // RULE_04
    end else if ((state == ST_EXEC) & ~suppress_q & (q_inc | q_dec)) begin
      skip_pend <= y_skip; // RULE_07 RULE_09
    end
  end

  // RAM write strobe after the old nibble has been read
  always @(posedge mclk_i) begin
    if (rst_i) begin
      ram_we    <= 1'b0;
      ram_wdata <= `NCTD_RST_NIB;
    end else begin
      ram_we <= 1'b0;
      if ((state == ST_EXEC) & ~suppress_q) begin
        if (q_swap) begin
          ram_we    <= 1'b1; // RULE_11 RULE_12 RULE_13 RULE_23
          ram_wdata <= acc;
        end
        if (op_q[`NCTD_OP_STORE_RAM]) begin
          ram_we    <= 1'b1; // RULE_14 RULE_23
          ram_wdata <= acc;
        end
      end
    end
  end

  // Accumulator
  always @(posedge mclk_i) begin
    if (rst_i) begin
      acc <= `NCTD_RST_NIB;
    end else if ((state == ST_EXEC) & ~suppress_q) begin
      if (op_q[`NCTD_OP_X_TO_ACC]) begin
        acc <= x; // RULE_01
      end
      if (op_q[`NCTD_OP_SP_TO_ACC]) begin
        acc <= {1'b0, stack_pointer_i}; // RULE_02
      end
      if (op_q[`NCTD_OP_LOAD_RAM] | q_swap) begin
        acc <= ram_rdata_i; // RULE_10 RULE_11 RULE_12 RULE_13
      end
      if (op_q[`NCTD_OP_B_TO_ACC]) begin
        acc <= b; // RULE_15
      end
      if (op_q[`NCTD_OP_Y_TO_ACC]) begin
        acc <= y; // RULE_17
      end
      if (op_q[`NCTD_OP_UNPACK_E]) begin
        acc <= e[3:0]; // RULE_20
      end
    end
  end

  // Registers B, D and E
  always @(posedge mclk_i) begin
    if (rst_i) begin
      b <= `NCTD_RST_NIB;
      d <= `NCTD_RST_D;
      e <= `NCTD_RST_E;
    end else if ((state == ST_EXEC) & ~suppress_q) begin
      if (op_q[`NCTD_OP_ACC_TO_B]) begin
        b <= acc; // RULE_16
      end
      if (op_q[`NCTD_OP_UNPACK_E]) begin
        b <= e[7:4]; // RULE_20
      end
      if (op_q[`NCTD_OP_PACK_E]) begin
        e <= {b, acc}; // RULE_19
      end
      if (op_q[`NCTD_OP_ACC_TO_D]) begin
        d <= acc[2:0]; // RULE_21
      end
    end
  end

  // Pointer registers X, Y and Z
  always @(posedge mclk_i) begin
    if (rst_i) begin
      x <= `NCTD_RST_NIB;
      y <= `NCTD_RST_NIB;
      z <= `NCTD_RST_Z;
    end else if ((state == ST_EXEC) & ~suppress_q) begin
      if (op_q[`NCTD_OP_LXY]) begin
        x <= instr_q[7:4]; // RULE_03
        y <= instr_q[3:0]; // RULE_03
      end
      if (op_q[`NCTD_OP_LZ]) begin
        z <= instr_q[1:0]; // RULE_05
      end
      if (q_xor) begin
        x <= x ^ imm_j; // RULE_10 RULE_11 RULE_12 RULE_13 RULE_14
      end
      if (q_inc | q_dec) begin
        y <= y_step; // RULE_06 RULE_08 RULE_12 RULE_13
      end
      if (op_q[`NCTD_OP_ACC_TO_Y]) begin
        y <= acc; // RULE_18
      end
    end
  end

  assign ready_o     = ready;
  assign done_o      = done;
  assign skipped_o   = skipped;
  assign ignored_o   = ignored;
  assign skip_next_o = skip_pend;
  assign acc_o       = acc;
  assign b_o         = b;
  assign d_o         = d;
  assign e_o         = e;
  assign x_o         = x;
  assign y_o         = y;
  assign z_o         = z;
  assign ram_addr_o  = ram_addr;
  assign ram_re_o    = ram_re;
  assign ram_we_o    = ram_we;
  assign ram_wdata_o = ram_wdata;

endmodule // nctd_core
`default_nettype wire

// ### verif/nctd_core_checker.sv
// Port timing and transfer checks for the transfer execute unit
`timescale 1ns/1ps
`default_nettype none
module nctd_core_checker #(
  parameter PTR_W = 6
) (
  // Clock, reset and issue
  input wire logic             mclk_i,
  input wire logic             rst_i,
  input wire logic             instr_valid_i,
  input wire logic [9:0]       instr_i,
  input wire logic [2:0]       stack_pointer_i,
  input wire logic [PTR_W-1:0] ram_data_pointer_i,
  // Status and registers
  input wire logic             ready_o,
  input wire logic             done_o,
  input wire logic             skipped_o,
  input wire logic             ignored_o,
  input wire logic             skip_next_o,
  input wire logic [3:0]       acc_o,
  input wire logic [3:0]       b_o,
  input wire logic [2:0]       d_o,
  input wire logic [7:0]       e_o,
  input wire logic [3:0]       x_o,
  input wire logic [3:0]       y_o,
  input wire logic [1:0]       z_o,
  // RAM port
  input wire logic [PTR_W-1:0] ram_addr_o,
  input wire logic             ram_re_o,
  input wire logic             ram_we_o,
  input wire logic [3:0]       ram_wdata_o,
  input wire logic [3:0]       ram_rdata_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; ready_o && instr_valid_i; endsequence
  sequence s_slot; (!ready_o && !done_o) [*2] ##1 (ready_o && done_o); endsequence
  sequence s_exec(logic [9:0] c); done_o && !skipped_o && $past(instr_i, 3) == c; endsequence
  property p_slot; s_take |=> s_slot; endproperty
  a_slot: assert property (p_slot) else $error("slot timing wrong");
  property p_we; ram_we_o |-> (done_o && !skipped_o && !ignored_o) ##1 !ram_we_o; endproperty
  a_we: assert property (p_we) else $error("write strobe wrong");
  property p_read; s_take ##0 (instr_i[9:6] == 4'hB && !skip_next_o) |=> ram_re_o && ram_addr_o == $past(ram_data_pointer_i); endproperty
  a_read: assert property (p_read) else $error("read strobe missing");
  property p_noram;
    s_take ##0 (instr_i[9:6] != 4'hB && instr_i[9:4] != 6'h2B) |=> !ram_re_o ##2 !ram_we_o;
  endproperty
  a_noram: assert property (p_noram) else $error("stray RAM access");
  property p_stwr;
    s_take ##0 (instr_i[9:4] == 6'h2B) |=> !ram_re_o ##2 (ram_we_o != $past(skip_next_o, 3));
  endproperty
  a_stwr: assert property (p_stwr) else $error("store strobe wrong");
  property p_inc; s_exec(10'h013) |-> skip_next_o == (y_o == 4'h0); endproperty
  a_inc: assert property (p_inc) else $error("increment skip wrong");
  property p_dec; s_exec(10'h017) |-> skip_next_o == (y_o == 4'hF); endproperty
  a_dec: assert property (p_dec) else $error("decrement skip wrong");
  property p_sp; s_exec(10'h050) |-> acc_o == {1'b0, stack_pointer_i}; endproperty
  a_sp: assert property (p_sp) else $error("stack pointer copy wrong");
  property p_xacc; s_exec(10'h052) |-> acc_o == $past(x_o); endproperty
  a_xacc: assert property (p_xacc) else $error("X copy wrong");
  property p_lxy;
    done_o && !skipped_o && $past(instr_i[9:8], 3) == 2'h3 |->
      x_o == $past(instr_i[7:4], 3) && y_o == $past(instr_i[3:0], 3);
  endproperty
  a_lxy: assert property (p_lxy) else $error("immediate load wrong");
  property p_skip; s_take ##0 skip_next_o |-> ##3 skipped_o; endproperty
  a_skip: assert property (p_skip) else $error("skip not taken");
  property p_hold; $changed(acc_o) |-> done_o; endproperty
  a_hold: assert property (p_hold) else $error("accumulator moved outside done");
  property p_store;
    done_o && !skipped_o && $past(instr_i[9:4], 3) == 6'h2B |-> ram_wdata_o == $past(acc_o) && acc_o == $past(acc_o);
  endproperty
  a_store: assert property (p_store) else $error("store data wrong");
endmodule // nctd_core_checker
bind nctd_core nctd_core_checker #(.PTR_W(PTR_W)) i_chk (.*);
`default_nettype wire

// ### verif/nibble_cpu_transfer_decoder_tb.sv
// Self-checking bench for the transfer execute unit
`timescale 1ns/1ps
`default_nettype none
module nibble_cpu_transfer_decoder_tb;
  logic       mclk_i = 1'b0, rst_i = 1'b1, instr_valid_i = 1'b0;
  logic [9:0] instr_i = 10'h000, w;
  logic [2:0] stack_pointer_i = 3'h0, m_d;
  logic [5:0] ram_data_pointer_i = 6'h00;
  logic [3:0] ram_rdata_i = 4'h0, m_acc, m_b, m_x, m_y, t, mem [64];
  wire        ready_o, done_o, skipped_o, ignored_o, skip_next_o, ram_re_o, ram_we_o;
  wire  [3:0] acc_o, b_o, x_o, y_o, ram_wdata_o;
  wire  [2:0] d_o;
  wire  [7:0] e_o;
  wire  [1:0] z_o;
  wire  [5:0] ram_addr_o;
  logic [7:0] m_e;
  logic [1:0] m_z;
  logic       m_skip, m_run, e_sk, e_ig, e_we;
  logic [31:0] seed = 32'd85337;
  int         err_count = 0, comparisons = 0, k;
  logic [9:0] base [19] = '{10'h052, 10'h050, 10'h300, 10'h048, 10'h013, 10'h017, 10'h2C0, 10'h2D0, 10'h2E0,
                            10'h2F0, 10'h2B0, 10'h01E, 10'h00E, 10'h01F, 10'h00C, 10'h01A, 10'h02A, 10'h029, 10'h000};
  // Run of immediates, Y wraps with skips, unknown code, RAM group
  logic [9:0] dir [14] = '{10'h3FF, 10'h312, 10'h300, 10'h013, 10'h052, 10'h017, 10'h2F3, 10'h000,
                           10'h2F3, 10'h2E5, 10'h2B1, 10'h2C2, 10'h050, 10'h029};

  nctd_core i_dut (.*);

  initial forever #5 mclk_i = ~mclk_i;

  // Synchronous RAM; read data turns over when not read
  always @(posedge mclk_i) begin
    if (ram_we_o) mem[ram_addr_o] <= ram_wdata_o;
    if (ram_re_o) ram_rdata_i <= mem[ram_addr_o];
    else ram_rdata_i <= ~ram_rdata_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic model(input logic [9:0] c, input logic [5:0] p, input logic [2:0] sp);
    e_sk = m_skip || (c[9:8] == 2'h3 && m_run);
    e_ig = 1'b0;
    e_we = 1'b0;
    t = m_acc;
    m_run = (c[9:8] == 2'h3);
    m_skip = 1'b0;
    if (!e_sk) casez (c)
      10'h052: m_acc = m_x;
      10'h050: m_acc = {1'b0, sp};
      10'b11????????: {m_x, m_y} = c[7:0];
      10'b00010010??: m_z = c[1:0];
      10'h013: begin m_y = m_y + 4'h1; m_skip = (m_y == 4'h0); end
      10'h017: begin m_y = m_y - 4'h1; m_skip = (m_y == 4'hF); end
      10'b101100????: begin m_acc = mem[p]; m_x = m_x ^ c[3:0]; end
      10'b101101????, 10'b10111?????: begin
        m_acc = mem[p];
        m_x = m_x ^ c[3:0];
        e_we = 1'b1;
        if (c[5:4] == 2'h2) begin m_y = m_y + 4'h1; m_skip = (m_y == 4'h0); end
        if (c[5:4] == 2'h3) begin m_y = m_y - 4'h1; m_skip = (m_y == 4'hF); end
      end
      10'b101011????: begin m_x = m_x ^ c[3:0]; e_we = 1'b1; end
      10'h01E: m_acc = m_b;
      10'h00E: m_b = m_acc;
      10'h01F: m_acc = m_y;
      10'h00C: m_y = m_acc;
      10'h01A: m_e = {m_b, m_acc};
      10'h02A: {m_b, m_acc} = m_e;
      10'h029: m_d = m_acc[2:0];
      default: e_ig = 1'b1;
    endcase
  endtask

  task automatic exec(input logic [9:0] c, input logic [5:0] p, input logic [2:0] sp);
    int n;
    n = 0;
    @(posedge mclk_i);
    instr_valid_i <= 1'b1;
    instr_i <= c;
    ram_data_pointer_i <= p;
    stack_pointer_i <= sp;
    do begin @(negedge mclk_i); n++; end while (ready_o !== 1'b1 && n < 20);
    @(posedge mclk_i);
    instr_valid_i <= 1'b0;
    model(c, p, sp);
    do begin @(negedge mclk_i); n++; end while (done_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      finish_test();
    end else begin
      chk(acc_o, m_acc);
      chk(b_o, m_b);
      chk(d_o, m_d);
      chk(e_o, m_e);
      chk(x_o, m_x);
      chk(y_o, m_y);
      chk(z_o, m_z);
      chk(skipped_o, e_sk);
      if (!e_sk) chk(ignored_o, e_ig);
      chk(skip_next_o, m_skip);
      chk(ram_we_o, e_we);
      if (e_we) chk(ram_wdata_o, t);
      chk(ram_addr_o, p);
    end
  endtask

  initial begin
    for (k = 0; k < 64; k++) mem[k] = 4'hA ^ k[3:0];
    {m_acc, m_b, m_x, m_y, m_d, m_e, m_z, m_skip, m_run} = '0;
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    foreach (dir[i]) exec(dir[i], 6'h05, 3'h5);
    for (int i = 0; i < 800; i++) begin
      seed = lfsr(seed);
      k = seed[20:12] % 19;
      w = base[k] | {2'h0, seed[31:24] & (k == 2 ? 8'hFF : k == 3 ? 8'h03 : (k > 5 && k < 11) ? 8'h0F : 8'h00)};
      exec(w, seed[5:0], seed[10:8]);
    end
    finish_test();
  end
endmodule // nibble_cpu_transfer_decoder_tb
`default_nettype wire
